// ### include/msef_map.vh
// Purpose: constants of the event flag block
// Assumes: included by the design files of the block
// Notes: definitions only
`ifndef MSEF_MAP_VH
`define MSEF_MAP_VH

// ----------------------------------------------------------------------
// event register bit positions
// ----------------------------------------------------------------------
`define MSEF_BIT_CONV_DONE 0
`define MSEF_BIT_RESULT_READY 1
`define MSEF_BIT_RESULT_MISSED 2
`define MSEF_BIT_INPUT_READY 3
`define MSEF_BIT_INPUT_MISSED 4
`define MSEF_BIT_OVERCURRENT 5
`define MSEF_LSB_INT_SENSOR 6
`define MSEF_LSB_REMOTE1 9
`define MSEF_LSB_REMOTE2 12
`define MSEF_BIT_SUPPLY_LOW 15

// ----------------------------------------------------------------------
// sensor sub-field positions
// ----------------------------------------------------------------------
`define MSEF_SENS_NEW 0
`define MSEF_SENS_LOW 1
`define MSEF_SENS_HIGH 2

// ----------------------------------------------------------------------
// converter sequencer modes
// ----------------------------------------------------------------------
`define MSEF_ADC_IDLE 2'h0
`define MSEF_ADC_SINGLE_CONV 2'h1
`define MSEF_ADC_SINGLE_SWEEP 2'h2
`define MSEF_ADC_CONT_SWEEP 2'h3

// ----------------------------------------------------------------------
// input event modes
// ----------------------------------------------------------------------
`define MSEF_GPI_NONE 2'h0
`define MSEF_GPI_RISE 2'h1
`define MSEF_GPI_FALL 2'h2
`define MSEF_GPI_BOTH 2'h3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MSEF_FLAGS_RST 16'h0000
`define MSEF_STATUS_RST 12'h000
`define MSEF_RDATA_RST 16'h0000
`define MSEF_AVG_CNT_RST 7'h00

`endif

// ### core/msef_sensor_cmp.v
// Purpose: limit comparison and new-sample pulse of one sensor
// Assumes: samples are 12-bit two's complement, 0.125 C per lsb
// Notes: outputs are one-cycle registered pulses
`timescale 1ns/100ps
`include "msef_map.vh"

module msef_sensor_cmp (
    input wire clk_in,
    input wire sys_rst_in,
    input wire sample_valid_in,
    input wire [11:0] sample_in,
    input wire [11:0] high_limit_in,
    input wire [11:0] low_limit_in,
    output reg [2:0] event_out
);

// ----------------------------------------------------------------------
// signed compare
// ----------------------------------------------------------------------
wire above_w;
wire below_w;
assign above_w = $signed(sample_in) > $signed(high_limit_in);
assign below_w = $signed(sample_in) < $signed(low_limit_in);

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        event_out <= 3'h0;
    end else begin
        event_out[`MSEF_SENS_HIGH] <= sample_valid_in & above_w;
        event_out[`MSEF_SENS_LOW] <= sample_valid_in & below_w;
        event_out[`MSEF_SENS_NEW] <= sample_valid_in;
    end
end

endmodule // msef_sensor_cmp

// ### core/msef_result_track.v
// Purpose: per-port averaging, result load and converter status
// Assumes: refresh_in marks end of conversion or sweep
// Notes: load and overwrite outputs are registered pulses
`timescale 1ns/100ps
`include "msef_map.vh"

module msef_result_track (
    input wire clk_in,
    input wire sys_rst_in,
    input wire refresh_in,
    input wire [11:0] port_sampled_in,
    input wire [35:0] avg_log2_in,
    input wire [11:0] result_read_in,
    input wire status_clear_in,
    output reg [11:0] result_load_out,
    output reg [11:0] status_out,
    output reg any_overwrite_out
);

// ----------------------------------------------------------------------
// averaging
// ----------------------------------------------------------------------
function [6:0] avg_last;
    input [2:0] log2;
    begin
        avg_last = (7'h01 << log2) - 7'h01;
    end
endfunction

reg [6:0] avg_cnt_q [0:11];
reg [11:0] unread_q;
reg [11:0] load_w;
integer i;
integer j;

always @* begin
    load_w = 12'h000;
    for (i = 0; i < 12; i = i + 1) begin
        load_w[i] = refresh_in & port_sampled_in[i] &
            (avg_cnt_q[i] == avg_last(avg_log2_in[3*i +: 3]));
    end
end

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        for (j = 0; j < 12; j = j + 1) begin
            avg_cnt_q[j] <= `MSEF_AVG_CNT_RST;
        end
        unread_q <= 12'h000;
        result_load_out <= 12'h000;
        status_out <= `MSEF_STATUS_RST;
        any_overwrite_out <= 1'b0;
    end else begin
        for (j = 0; j < 12; j = j + 1) begin
            if (load_w[j]) begin
                avg_cnt_q[j] <= `MSEF_AVG_CNT_RST;
            end else if (refresh_in & port_sampled_in[j]) begin
                avg_cnt_q[j] <= avg_cnt_q[j] + 7'h01;
            end
        end
        result_load_out <= load_w;
        unread_q <= (unread_q & ~result_read_in) | load_w;
        any_overwrite_out <= |(load_w & unread_q & ~result_read_in);
        status_out <= (status_out & ~{12{status_clear_in}}) | load_w;
    end
end

endmodule // msef_result_track

// ### core/msef_flags.v
// Purpose: sticky event flag register and part identifier
// Assumes: read strobes are one-cycle pulses from the serial front end
// Notes: read data is held in rd_data_out until the next read
`timescale 1ns/100ps
`include "msef_map.vh"

module msef_flags #(
    parameter [15:0] PART_ID_CODE = 16'hA5C3 // value is arbitrary
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [1:0] adc_mode_in,
    input wire conv_done_in,
    input wire sweep_done_in,
    input wire [11:0] port_sampled_in,
    input wire [35:0] avg_log2_in,
    input wire [11:0] result_read_in,
    input wire [11:0] gpi_level_in,
    input wire [23:0] gpi_mode_in,
    input wire [11:0] overcurrent_in,
    input wire supply_low_in,
    input wire int_sample_valid_in,
    input wire [11:0] int_sample_in,
    input wire [11:0] int_high_limit_in,
    input wire [11:0] int_low_limit_in,
    input wire rem1_sample_valid_in,
    input wire [11:0] rem1_sample_in,
    input wire [11:0] rem1_high_limit_in,
    input wire [11:0] rem1_low_limit_in,
    input wire rem2_sample_valid_in,
    input wire [11:0] rem2_sample_in,
    input wire [11:0] rem2_high_limit_in,
    input wire [11:0] rem2_low_limit_in,
    input wire part_id_rd_in,
    input wire event_rd_in,
    input wire conv_status_lo_rd_in,
    input wire conv_status_hi_rd_in,
    input wire input_status_lo_rd_in,
    input wire input_status_hi_rd_in,
    input wire oc_status_lo_rd_in,
    input wire oc_status_hi_rd_in,
    output reg [15:0] rd_data_out,
    output reg [15:0] event_flags_out,
    output wire [11:0] result_load_out
);

// ----------------------------------------------------------------------
// clear sequencer states
// ----------------------------------------------------------------------
localparam [3:0] CLR_IDLE = 4'h1;
localparam [3:0] CLR_ARMED = 4'h2;
localparam [3:0] CLR_GOT_LO = 4'h4;
localparam [3:0] CLR_GOT_HI = 4'h8;

// both status halves read after an event read
function clr_done;
    input [3:0] state;
    input ev_rd;
    input lo_rd;
    input hi_rd;
    begin
        case (state)
            CLR_ARMED: clr_done = ~ev_rd & lo_rd & hi_rd;
            CLR_GOT_LO: clr_done = ~ev_rd & hi_rd;
            CLR_GOT_HI: clr_done = ~ev_rd & lo_rd;
            default: clr_done = 1'b0;
        endcase
    end
endfunction

function [3:0] clr_next;
    input [3:0] state;
    input ev_rd;
    input lo_rd;
    input hi_rd;
    begin
        if (ev_rd) begin
            clr_next = CLR_ARMED;
        end else begin
            case (state)
                CLR_IDLE: clr_next = CLR_IDLE;
                CLR_ARMED: begin
                    if (lo_rd & hi_rd) begin
                        clr_next = CLR_IDLE;
                    end else if (lo_rd) begin
                        clr_next = CLR_GOT_LO;
                    end else if (hi_rd) begin
                        clr_next = CLR_GOT_HI;
                    end else begin
                        clr_next = CLR_ARMED;
                    end
                end
                CLR_GOT_LO: clr_next = hi_rd ? CLR_IDLE : CLR_GOT_LO;
                CLR_GOT_HI: clr_next = lo_rd ? CLR_IDLE : CLR_GOT_HI;
                default: clr_next = CLR_IDLE;
            endcase
        end
    end
endfunction

// status halves as read: ports 10:0 low, port 11 high
function [15:0] status_lo;
    input [11:0] st;
    begin
        status_lo = {5'h00, st[10:0]};
    end
endfunction

function [15:0] status_hi;
    input [11:0] st;
    begin
        status_hi = {15'h0000, st[11]};
    end
endfunction

// ----------------------------------------------------------------------
// declarations
// ----------------------------------------------------------------------
reg [3:0] conv_clr_q;
reg [3:0] input_clr_q;
reg [3:0] oc_clr_q;
reg [11:0] gpi_prev_q;
reg [11:0] input_status_q;
reg [11:0] oc_status_q;
reg [15:0] flags_d;
reg [15:0] set_w;
reg [15:0] clr_w;
reg [11:0] gpi_event_w;
wire refresh_w;
wire conv_clear_w;
wire input_clear_w;
wire oc_clear_w;
wire [11:0] conv_status_w;
wire conv_overwrite_w;
wire [2:0] int_event_w;
wire [2:0] rem1_event_w;
wire [2:0] rem2_event_w;
wire input_overwrite_w;
integer i;

// ----------------------------------------------------------------------
// conversion refresh point
// ----------------------------------------------------------------------
assign refresh_w = ((adc_mode_in == `MSEF_ADC_SINGLE_CONV) & conv_done_in) |
    (((adc_mode_in == `MSEF_ADC_SINGLE_SWEEP) |
      (adc_mode_in == `MSEF_ADC_CONT_SWEEP)) & sweep_done_in);

// ----------------------------------------------------------------------
// clear sequencers
// ----------------------------------------------------------------------
assign conv_clear_w = clr_done(conv_clr_q, event_rd_in,
    conv_status_lo_rd_in, conv_status_hi_rd_in);
assign input_clear_w = clr_done(input_clr_q, event_rd_in,
    input_status_lo_rd_in, input_status_hi_rd_in);
assign oc_clear_w = clr_done(oc_clr_q, event_rd_in,
    oc_status_lo_rd_in, oc_status_hi_rd_in);

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        conv_clr_q <= CLR_IDLE;
        input_clr_q <= CLR_IDLE;
        oc_clr_q <= CLR_IDLE;
    end else begin
        conv_clr_q <= clr_next(conv_clr_q, event_rd_in,
            conv_status_lo_rd_in, conv_status_hi_rd_in);
        input_clr_q <= clr_next(input_clr_q, event_rd_in,
            input_status_lo_rd_in, input_status_hi_rd_in);
        oc_clr_q <= clr_next(oc_clr_q, event_rd_in,
            oc_status_lo_rd_in, oc_status_hi_rd_in);
    end
end

// ----------------------------------------------------------------------
// converter results
// ----------------------------------------------------------------------
msef_result_track u_result (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .refresh_in(refresh_w),
    .port_sampled_in(port_sampled_in),
    .avg_log2_in(avg_log2_in),
    .result_read_in(result_read_in),
    .status_clear_in(conv_clear_w),
    .result_load_out(result_load_out),
    .status_out(conv_status_w),
    .any_overwrite_out(conv_overwrite_w)
);

// ----------------------------------------------------------------------
// temperature sensors
// ----------------------------------------------------------------------
msef_sensor_cmp u_int_sensor (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(int_sample_valid_in),
    .sample_in(int_sample_in),
    .high_limit_in(int_high_limit_in),
    .low_limit_in(int_low_limit_in),
    .event_out(int_event_w)
);

msef_sensor_cmp u_rem1_sensor (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(rem1_sample_valid_in),
    .sample_in(rem1_sample_in),
    .high_limit_in(rem1_high_limit_in),
    .low_limit_in(rem1_low_limit_in),
    .event_out(rem1_event_w)
);

msef_sensor_cmp u_rem2_sensor (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(rem2_sample_valid_in),
    .sample_in(rem2_sample_in),
    .high_limit_in(rem2_high_limit_in),
    .low_limit_in(rem2_low_limit_in),
    .event_out(rem2_event_w)
);

// ----------------------------------------------------------------------
// input port events
// ----------------------------------------------------------------------
always @* begin
    gpi_event_w = 12'h000;
    for (i = 0; i < 12; i = i + 1) begin
        case (gpi_mode_in[2*i +: 2])
            `MSEF_GPI_RISE: gpi_event_w[i] = gpi_level_in[i] & ~gpi_prev_q[i];
            `MSEF_GPI_FALL: gpi_event_w[i] = ~gpi_level_in[i] & gpi_prev_q[i];
            `MSEF_GPI_BOTH: gpi_event_w[i] = gpi_level_in[i] ^ gpi_prev_q[i];
            default: gpi_event_w[i] = 1'b0;
        endcase
    end
end

// new event while status still holds an unread event
assign input_overwrite_w = (|gpi_event_w) & (|input_status_q) &
    ~input_clear_w;

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        gpi_prev_q <= gpi_level_in;
        input_status_q <= `MSEF_STATUS_RST;
        oc_status_q <= `MSEF_STATUS_RST;
    end else begin
        gpi_prev_q <= gpi_level_in;
        input_status_q <= (input_status_q & ~{12{input_clear_w}}) |
            gpi_event_w;
        oc_status_q <= (oc_status_q & ~{12{oc_clear_w}}) |
            overcurrent_in;
    end
end

// ----------------------------------------------------------------------
// event flag register
// ----------------------------------------------------------------------
always @* begin
    set_w = 16'h0000;
    clr_w = 16'h0000;
    set_w[`MSEF_BIT_CONV_DONE] = refresh_w;
    set_w[`MSEF_BIT_RESULT_READY] = |result_load_out;
    set_w[`MSEF_BIT_RESULT_MISSED] = conv_overwrite_w;
    set_w[`MSEF_BIT_INPUT_READY] = |gpi_event_w;
    set_w[`MSEF_BIT_INPUT_MISSED] = input_overwrite_w;
    set_w[`MSEF_BIT_OVERCURRENT] = |overcurrent_in;
    set_w[`MSEF_LSB_INT_SENSOR +: 3] = int_event_w;
    set_w[`MSEF_LSB_REMOTE1 +: 3] = rem1_event_w;
    set_w[`MSEF_LSB_REMOTE2 +: 3] = rem2_event_w;
    set_w[`MSEF_BIT_SUPPLY_LOW] = supply_low_in;
    clr_w[`MSEF_BIT_CONV_DONE] = event_rd_in;
    clr_w[`MSEF_BIT_RESULT_READY] = conv_clear_w;
    clr_w[`MSEF_BIT_RESULT_MISSED] = event_rd_in;
    clr_w[`MSEF_BIT_INPUT_READY] = input_clear_w;
    clr_w[`MSEF_BIT_INPUT_MISSED] = input_clear_w;
    clr_w[`MSEF_BIT_OVERCURRENT] = oc_clear_w;
    clr_w[`MSEF_LSB_INT_SENSOR +: 3] = {3{event_rd_in}};
    clr_w[`MSEF_LSB_REMOTE1 +: 3] = {3{event_rd_in}};
    clr_w[`MSEF_LSB_REMOTE2 +: 3] = {3{event_rd_in}};
    clr_w[`MSEF_BIT_SUPPLY_LOW] = event_rd_in;
    flags_d = (event_flags_out & ~clr_w) | set_w;
end

always @(posedge clk_in) begin
    if (sys_rst_in) begin
        event_flags_out <= `MSEF_FLAGS_RST;
    end else begin
        event_flags_out <= flags_d;
    end
end

// ----------------------------------------------------------------------
// read data
// ----------------------------------------------------------------------
always @(posedge clk_in) begin
    if (sys_rst_in) begin
        rd_data_out <= `MSEF_RDATA_RST;
    end else if (event_rd_in) begin
        rd_data_out <= event_flags_out;
    end else if (part_id_rd_in) begin
        rd_data_out <= PART_ID_CODE;
    end else if (conv_status_lo_rd_in) begin
        rd_data_out <= status_lo(conv_status_w);
    end else if (conv_status_hi_rd_in) begin
        rd_data_out <= status_hi(conv_status_w);
    end else if (input_status_lo_rd_in) begin
        rd_data_out <= status_lo(input_status_q);
    end else if (input_status_hi_rd_in) begin
        rd_data_out <= status_hi(input_status_q);
    end else if (oc_status_lo_rd_in) begin
        rd_data_out <= status_lo(oc_status_q);
    end else if (oc_status_hi_rd_in) begin
        rd_data_out <= status_hi(oc_status_q);
    end
end

endmodule // msef_flags

// ### sim/msef_flags_props.sv
// Purpose: port assertions of the event flag block
// Assumes: bound to msef_flags, one clock domain
// Notes: read data checked one cycle after its strobe
`timescale 1ns/100ps
module msef_flags_props #(
    parameter [15:0] PART_ID_CODE = 16'hA5C3 // value is arbitrary
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire [1:0] adc_mode_in,
    input wire conv_done_in,
    input wire sweep_done_in,
    input wire [11:0] overcurrent_in,
    input wire supply_low_in,
    input wire part_id_rd_in,
    input wire event_rd_in,
    input wire [15:0] rd_data_out,
    input wire [15:0] event_flags_out,
    input wire [11:0] result_load_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_id_read;
        part_id_rd_in && !event_rd_in |=> rd_data_out == PART_ID_CODE;
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identifier read wrong");
    property p_done_set;
        (adc_mode_in == 2'h1 && conv_done_in) ||
            (adc_mode_in[1] && sweep_done_in) |=> event_flags_out[0];
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("completion flag not set");
    property p_done_clr;
        event_rd_in && !conv_done_in && !sweep_done_in
            |=> !event_flags_out[0];
    endproperty
    a_done_clr: assert property (p_done_clr)
        else $error("completion flag not cleared");
    property p_idle_flag;
        adc_mode_in == 2'h0 && !event_flags_out[0] |=> !event_flags_out[0];
    endproperty
    a_idle_flag: assert property (p_idle_flag)
        else $error("completion flag while idle");
    property p_idle_load;
        adc_mode_in == 2'h0 |=> result_load_out == 12'h000;
    endproperty
    a_idle_load: assert property (p_idle_load)
        else $error("result load while idle");
    property p_load_ready;
        |result_load_out |=> event_flags_out[1];
    endproperty
    a_load_ready: assert property (p_load_ready)
        else $error("data ready flag missing");
    property p_oc_set;
        |overcurrent_in |=> event_flags_out[5];
    endproperty
    a_oc_set: assert property (p_oc_set)
        else $error("overcurrent flag missing");
    property p_supply_set;
        supply_low_in |=> event_flags_out[15];
    endproperty
    a_supply_set: assert property (p_supply_set)
        else $error("supply flag missing");
    property p_supply_clr;
        event_rd_in && !supply_low_in |=> !event_flags_out[15];
    endproperty
    a_supply_clr: assert property (p_supply_clr)
        else $error("supply flag not cleared");
    property p_snapshot;
        event_rd_in |=> rd_data_out == $past(event_flags_out);
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("event read not a snapshot");
endmodule // msef_flags_props

bind msef_flags msef_flags_props #(.PART_ID_CODE(PART_ID_CODE)) i_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .adc_mode_in(adc_mode_in),
    .conv_done_in(conv_done_in), .sweep_done_in(sweep_done_in),
    .overcurrent_in(overcurrent_in), .supply_low_in(supply_low_in),
    .part_id_rd_in(part_id_rd_in), .event_rd_in(event_rd_in),
    .rd_data_out(rd_data_out), .event_flags_out(event_flags_out),
    .result_load_out(result_load_out));

// ### sim/msef_host_model.sv
// Purpose: host side reading registers through one-cycle strobes
// Assumes: strobe bits select one register each
// Notes: strobes change at the falling edge
`timescale 1ns/100ps
module msef_host_model (
    input wire clk_in,
    input wire [15:0] rd_data_in,
    output reg [7:0] strobe_out
);
    initial strobe_out = 8'h00;
    // one read, data taken once it has settled
    task read_reg(input [7:0] sel, output [15:0] data);
        begin
            @(negedge clk_in);
            strobe_out = sel;
            @(negedge clk_in);
            strobe_out = 8'h00;
            @(negedge clk_in);
            data = rd_data_in;
        end
    endtask
endmodule // msef_host_model

// ### sim/testbench.sv
// Purpose: self-checking bench of the event flag block
// Assumes: host model issues all register reads
// Notes: inputs driven at the falling edge
`timescale 1ns/100ps
module testbench;
    localparam [15:0] ID_CODE = 16'h5A3C; // value is arbitrary
    localparam [7:0] RD_ID = 8'h01;
    localparam [7:0] RD_EV = 8'h02;
    localparam [7:0] RD_CONV = 8'h04;
    localparam [7:0] RD_IN = 8'h10;
    localparam [7:0] RD_OC = 8'h40;
    reg clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg [1:0] mode = 2'h0;
    reg conv_done = 1'b0;
    reg sweep_done = 1'b0;
    reg [11:0] sampled = 12'h000;
    reg [35:0] avg_log2 = 36'h0;
    reg [11:0] res_read = 12'h000;
    reg [11:0] gpi_level = 12'h000;
    reg [23:0] gpi_mode = 24'h0;
    reg [11:0] oc = 12'h000;
    reg supply_low = 1'b0;
    reg [2:0] s_valid = 3'h0;
    reg [11:0] s_smp = 12'h000;
    reg [11:0] s_hi = 12'h7FE;
    reg [11:0] s_lo = 12'h801;
    reg [15:0] exp_v;
    wire [15:0] rd_data;
    wire [7:0] stb;
    integer num_errors = 0;
    integer total_checks = 0;
    integer i;

    msef_flags #(.PART_ID_CODE(ID_CODE)) i_dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .adc_mode_in(mode),
        .conv_done_in(conv_done), .sweep_done_in(sweep_done),
        .port_sampled_in(sampled), .avg_log2_in(avg_log2),
        .result_read_in(res_read), .gpi_level_in(gpi_level),
        .gpi_mode_in(gpi_mode), .overcurrent_in(oc),
        .supply_low_in(supply_low), .int_sample_valid_in(s_valid[0]),
        .int_sample_in(s_smp), .int_high_limit_in(s_hi),
        .int_low_limit_in(s_lo), .rem1_sample_valid_in(s_valid[1]),
        .rem1_sample_in(s_smp), .rem1_high_limit_in(s_hi),
        .rem1_low_limit_in(s_lo), .rem2_sample_valid_in(s_valid[2]),
        .rem2_sample_in(s_smp), .rem2_high_limit_in(s_hi),
        .rem2_low_limit_in(s_lo), .part_id_rd_in(stb[0]),
        .event_rd_in(stb[1]), .conv_status_lo_rd_in(stb[2]),
        .conv_status_hi_rd_in(stb[3]), .input_status_lo_rd_in(stb[4]),
        .input_status_hi_rd_in(stb[5]), .oc_status_lo_rd_in(stb[6]),
        .oc_status_hi_rd_in(stb[7]), .rd_data_out(rd_data),
        .event_flags_out(), .result_load_out());
    msef_host_model i_host (.clk_in(clk_in), .rd_data_in(rd_data),
        .strobe_out(stb));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end
    task tally_and_finish;
        begin
            if (num_errors == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [7:0] sel, input [15:0] seen, input [15:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH rd_data sel=%h exp=%h seen=%h",
                    sel, exp, seen);
            end
        end
    endtask
    task rd_chk(input [7:0] sel, input [15:0] exp);
        reg [15:0] d;
        begin
            i_host.read_reg(sel, d);
            chk(sel, d, exp);
        end
    endtask
    task clr(input [7:0] sel);
        reg [15:0] d;
        begin
            i_host.read_reg(sel, d);
            i_host.read_reg({sel[6:0], 1'b0}, d);
        end
    endtask
    task done_pulse(input conv, input rd);
        begin
            res_read = {11'h000, rd};
            @(negedge clk_in);
            res_read = 12'h000;
            conv_done = conv;
            sweep_done = !conv;
            @(negedge clk_in);
            conv_done = 1'b0;
            sweep_done = 1'b0;
            repeat (4) @(negedge clk_in);
        end
    endtask
    task sens(input integer idx, input [11:0] smp);
        begin
            s_smp = smp;
            s_valid = 3'h1 << idx;
            @(negedge clk_in);
            s_valid = 3'h0;
            repeat (4) @(negedge clk_in);
        end
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk_in);
        num_errors = num_errors + 1;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(negedge clk_in);
        sys_rst_in = 1'b0;
        rd_chk(RD_ID, ID_CODE);
        sampled = 12'h001;
        done_pulse(1'b1, 1'b0);
        done_pulse(1'b0, 1'b0);
        rd_chk(RD_EV, 16'h0000);
        mode = 2'h1;
        done_pulse(1'b1, 1'b0);
        rd_chk(RD_EV, 16'h0003);
        rd_chk(RD_EV, 16'h0002);
        rd_chk(RD_CONV, 16'h0001);
        rd_chk(RD_CONV << 1, 16'h0000);
        rd_chk(RD_EV, 16'h0000);
        mode = 2'h2;
        done_pulse(1'b0, 1'b1);
        done_pulse(1'b0, 1'b1);
        rd_chk(RD_EV, 16'h0003);
        done_pulse(1'b0, 1'b0);
        rd_chk(RD_EV, 16'h0007);
        rd_chk(RD_EV, 16'h0002);
        clr(RD_CONV);
        rd_chk(RD_EV, 16'h0000);
        mode = 2'h3;
        avg_log2 = 36'h2;
        for (i = 0; i < 3; i = i + 1)
            done_pulse(1'b0, 1'b1);
        rd_chk(RD_EV, 16'h0001);
        done_pulse(1'b0, 1'b1);
        rd_chk(RD_EV, 16'h0003);
        clr(RD_CONV);
        mode = 2'h0;
        for (i = 0; i < 4; i = i + 1) begin
            gpi_mode = {18'h0, i[1:0], 4'h0};
            exp_v = (i == 0) ? 16'h0 : (i == 3) ? 16'h0018 : 16'h0008;
            @(negedge clk_in);
            gpi_level = 12'h004;
            repeat (2) @(negedge clk_in);
            gpi_level = 12'h000;
            repeat (3) @(negedge clk_in);
            rd_chk(RD_EV, exp_v);
            rd_chk(RD_IN, (i == 0) ? 16'h0000 : 16'h0004);
            rd_chk(RD_IN << 1, 16'h0000);
            rd_chk(RD_EV, 16'h0000);
        end
        oc = 12'h800;
        repeat (3) @(negedge clk_in);
        oc = 12'h000;
        rd_chk(RD_EV, 16'h0020);
        rd_chk(RD_OC, 16'h0000);
        rd_chk(RD_OC << 1, 16'h0001);
        rd_chk(RD_EV, 16'h0000);
        for (i = 0; i < 3; i = i + 1) begin
            sens(i, 12'h800);
            rd_chk(RD_EV, 16'h3 << (6 + 3 * i));
            sens(i, 12'h7FF);
            rd_chk(RD_EV, 16'h5 << (6 + 3 * i));
            sens(i, 12'h000);
            rd_chk(RD_EV, 16'h1 << (6 + 3 * i));
        end
        supply_low = 1'b1;
        repeat (2) @(negedge clk_in);
        rd_chk(RD_EV, 16'h8000);
        rd_chk(RD_EV, 16'h8000);
        supply_low = 1'b0;
        rd_chk(RD_EV, 16'h8000);
        rd_chk(RD_EV, 16'h0000);
        tally_and_finish;
    end
endmodule // testbench
